// [rtl/charge_port_pkg.sv]
`default_nettype none
package charge_port_pkg;
  localparam longint CLK_KHZ = 64'd250000;
  localparam longint LOAD_ON_MS = 64'd200;
  localparam longint LOAD_OFF_MS = 64'd3000;
  localparam longint PW_IDLE_MS = 64'd15000;
  localparam longint PW_DISCH_MS = 64'd330;
  localparam longint PORT_DISCH_MS = 64'd10;
  localparam longint CL_DEGLITCH_MS = 64'd8;
  localparam longint DIV_B_TEST_MS = 64'd100;
  localparam longint LOAD_ON_CYC = LOAD_ON_MS * CLK_KHZ;
  localparam longint LOAD_OFF_CYC = LOAD_OFF_MS * CLK_KHZ;
  localparam longint PW_IDLE_CYC = PW_IDLE_MS * CLK_KHZ;
  localparam longint PW_DISCH_CYC = PW_DISCH_MS * CLK_KHZ + 64'd1;
  localparam longint PORT_DISCH_CYC = PORT_DISCH_MS * CLK_KHZ;
  localparam longint CL_DEGLITCH_CYC = CL_DEGLITCH_MS * CLK_KHZ;
  localparam longint DIV_B_TEST_CYC = DIV_B_TEST_MS * CLK_KHZ;

  typedef enum logic [2:0] {ST_OFF = 3'b001, ST_DISCH = 3'b010, ST_RUN = 3'b100} port_state_t;
  typedef enum logic [1:0] {SCH_NONE = 2'h0, SCH_DIV_A = 2'h1, SCH_DIV_B = 2'h2, SCH_SHORT = 2'h3} line_scheme_t;
  typedef enum logic [2:0] {
    CL_DISCH = 3'h0, CL_AUTO = 3'h1, CL_HOST = 3'h2, CL_SHORT = 3'h3, CL_DIV_A = 3'h4
  } mode_class_t;

  typedef struct packed {
    logic enable;
    logic mode_select_bit1;
    logic mode_select_bit2;
    logic mode_select_bit3;
    logic limit_select;
    logic supply_above_on;
    logic supply_below_off;
    logic temp_over_135;
    logic temp_over_155;
    logic temp_cooled;
    logic current_limit;
    logic output_short;
    logic load_above_hi;
    logic load_below_lo;
    logic pw_idle_low;
    logic pw_limit_hit;
    logic charge_over_750;
    logic shorted_dev_seen;
    logic data_line_release;
    logic high_current_on;
    logic primary_detect;
  } pin_sense_t;
endpackage
`default_nettype wire

// [rtl/charge_port_ctrl.sv]
`default_nettype none
module charge_port_ctrl import charge_port_pkg::*; #(
  parameter logic [31:0] LOAD_ON_CNT = 32'(LOAD_ON_CYC),
  parameter logic [31:0] LOAD_OFF_CNT = 32'(LOAD_OFF_CYC),
  parameter logic [31:0] PW_IDLE_CNT = 32'(PW_IDLE_CYC),
  parameter logic [31:0] PW_DISCH_CNT = 32'(PW_DISCH_CYC),
  parameter logic [31:0] PORT_DISCH_CNT = 32'(PORT_DISCH_CYC),
  parameter logic [31:0] CL_DEGLITCH_CNT = 32'(CL_DEGLITCH_CYC),
  parameter logic [31:0] DIV_B_TEST_CNT = 32'(DIV_B_TEST_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pin_sense_t pins_in,
  output logic power_switch_on_out,
  output logic constant_current_out,
  output logic discharge_out,
  output logic data_switch_on_out,
  output line_scheme_t scheme_out,
  output logic high_current_limit_out,
  output logic low_current_limit_out,
  output logic pw_limit_out,
  output logic fault_n_out,
  output logic fault_oe_out,
  output logic status_n_out,
  output logic status_oe_out
);
  // ****************************************
  // input synchronisers
  // ****************************************
  pin_sense_t meta_q, pin_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      pin_q <= '0;
    end else begin
      meta_q <= pins_in;
      pin_q <= meta_q;
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  wire [2:0] mode_bits = {pin_q.mode_select_bit1, pin_q.mode_select_bit2, pin_q.mode_select_bit3};
  wire sel = pin_q.limit_select;
  mode_class_t class_d, class_q;
  assign class_d = (mode_bits == 3'h0) ? CL_DISCH :
                   (mode_bits == 3'h1 || mode_bits == 3'h3) ? CL_AUTO :
                   (mode_bits == 3'h4) ? CL_SHORT :
                   (mode_bits == 3'h5) ? CL_DIV_A : CL_HOST;
  // power wake only in 001 with limit select high
  wire pw_mode = (mode_bits == 3'h1) && sel;
  // threshold load detection in charging host and 011
  wire ld_mode = sel && ((mode_bits == 3'h3) || (mode_bits == 3'h7));
  wire cdp_mode = sel && (mode_bits == 3'h7);
  // forced modes start and stay in one scheme
  line_scheme_t init_sch;
  assign init_sch = (class_d == CL_AUTO || class_d == CL_DIV_A) ? SCH_DIV_A :
                    (class_d == CL_SHORT) ? SCH_SHORT : SCH_NONE;

  // ****************************************
  // supply lockout and thermal
  // ****************************************
  logic supply_ok_q, thermal_off_q;
  wire therm_trip = pin_q.temp_over_155 || (pin_q.temp_over_135 && pin_q.current_limit);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_ok_q <= 1'b0;
      thermal_off_q <= 1'b0;
    end else begin
      // hysteresis between turn-on and turn-off points
      if (pin_q.supply_above_on) begin
        supply_ok_q <= 1'b1;
      end else if (pin_q.supply_below_off) begin
        supply_ok_q <= 1'b0;
      end
      // restart once cooled, trip again if fault remains
      if (therm_trip) begin
        thermal_off_q <= 1'b1;
      end else if (pin_q.temp_cooled) begin
        thermal_off_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // port sequencer
  // ****************************************
  port_state_t state_q, state_d;
  line_scheme_t scheme_q, pend_q;
  logic [31:0] disch_cnt_q, test_cnt_q, pw_cnt_q, ld_cnt_q, cl_cnt_q;
  logic pw_limit_q, pw_disch_q, load_q;
  wire run_ok = pin_q.enable && supply_ok_q && (class_d != CL_DISCH);
  wire in_run = (state_q == ST_RUN);
  wire auto_run = in_run && (class_d == CL_AUTO);
  // host variants share a class, so no discharge between them
  wire class_chg = in_run && (class_d != class_q);
  // shorted-line device seen in scheme a
  wire go_short = auto_run && (scheme_q == SCH_DIV_A) && pin_q.shorted_dev_seen;
  // heavy draw in scheme a, otherwise stays
  wire go_div_b = auto_run && (scheme_q == SCH_DIV_A) && !pin_q.shorted_dev_seen && pin_q.charge_over_750;
  wire test_done = (test_cnt_q >= DIV_B_TEST_CNT);
  // scheme b fails when high current stops
  wire div_b_fail = auto_run && (scheme_q == SCH_DIV_B) && test_done && !pin_q.high_current_on;
  // release of the data line returns to scheme a
  wire line_free = auto_run && (scheme_q == SCH_SHORT) && pin_q.data_line_release;
  // wake on hitting the 55 mA limit
  wire pw_hit = in_run && pw_mode && pw_limit_q && pin_q.pw_limit_hit;
  wire need_disch = class_chg || go_short || go_div_b || div_b_fail || pw_hit;
  line_scheme_t pend_d;
  assign pend_d = class_chg ? init_sch : go_short ? SCH_SHORT : go_div_b ? SCH_DIV_B :
                  div_b_fail ? SCH_DIV_A : scheme_q;
  wire [31:0] disch_len = pw_hit ? PW_DISCH_CNT : PORT_DISCH_CNT;
  wire disch_end = (state_q == ST_DISCH) && (disch_cnt_q <= 32'h1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (run_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_DISCH: begin
        if (!run_ok) begin
          state_d = ST_OFF;
        end else if (disch_end) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_ok) begin
          state_d = ST_OFF;
        end else if (need_disch) begin
          state_d = ST_DISCH;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_OFF;
      class_q <= CL_DISCH;
      scheme_q <= SCH_NONE;
      pend_q <= SCH_NONE;
      disch_cnt_q <= 32'h0;
      pw_disch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      class_q <= class_d;
      if (state_q == ST_RUN && state_d == ST_DISCH) begin
        // switch off and discharge before the new signalling
        pend_q <= pend_d;
        disch_cnt_q <= disch_len;
        pw_disch_q <= pw_hit;
      end else if (state_q == ST_DISCH) begin
        disch_cnt_q <= disch_cnt_q - 32'h1;
      end
      if (state_q == ST_OFF) begin
        // first scheme after power-up is init_sch: scheme a in auto and 101, shorted in 100, none in host modes
        scheme_q <= init_sch;
      end else if (disch_end) begin
        scheme_q <= pend_q;
      end else if (line_free) begin
        scheme_q <= SCH_DIV_A;
      end
    end
  end

  // ****************************************
  // timers
  // ****************************************
  wire ld_cond = load_q ? pin_q.load_below_lo : pin_q.load_above_hi;
  wire [31:0] ld_lim = load_q ? LOAD_OFF_CNT : LOAD_ON_CNT;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      test_cnt_q <= 32'h0;
      pw_cnt_q <= 32'h0;
      pw_limit_q <= 1'b0;
      ld_cnt_q <= 32'h0;
      load_q <= 1'b0;
      cl_cnt_q <= 32'h0;
    end else begin
      test_cnt_q <= (auto_run && scheme_q == SCH_DIV_B && !test_done) ? test_cnt_q + 32'h1 :
                    (auto_run && scheme_q == SCH_DIV_B) ? test_cnt_q : 32'h0;
      // long idle drops to the 55 mA limit
      if (!pw_mode || state_q == ST_OFF) begin
        pw_cnt_q <= 32'h0;
        pw_limit_q <= 1'b0;
      end else if (disch_end && pw_disch_q) begin
        pw_limit_q <= 1'b0;
      end else if (in_run && !pw_limit_q) begin
        pw_cnt_q <= pin_q.pw_idle_low ? pw_cnt_q + 32'h1 : 32'h0;
        if (pw_cnt_q >= PW_IDLE_CNT) begin
          pw_limit_q <= 1'b1;
          pw_cnt_q <= 32'h0;
        end
      end
      if (!ld_mode || state_q == ST_OFF) begin
        ld_cnt_q <= 32'h0;
        load_q <= 1'b0;
      end else if (cdp_mode && pin_q.primary_detect && !load_q) begin
        load_q <= 1'b1;
        ld_cnt_q <= 32'h0;
      end else if (!ld_cond) begin
        ld_cnt_q <= 32'h0;
      end else if (ld_cnt_q >= ld_lim - 32'h1) begin
        load_q <= !load_q;
        ld_cnt_q <= 32'h0;
      end else begin
        ld_cnt_q <= ld_cnt_q + 32'h1;
      end
      cl_cnt_q <= !pin_q.current_limit ? 32'h0 :
                  (cl_cnt_q < CL_DEGLITCH_CNT) ? cl_cnt_q + 32'h1 : cl_cnt_q;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // over-temperature reports at once
  wire fault_d = thermal_off_q || therm_trip || (cl_cnt_q >= CL_DEGLITCH_CNT);
  wire switch_d = in_run && supply_ok_q && !thermal_off_q;
  // host modes only, never while discharging
  wire data_d = in_run && pin_q.enable && (class_d == CL_HOST);
  wire status_d = pw_mode ? (in_run && !pw_limit_q) || (state_q == ST_DISCH && pw_disch_q) : load_q;
  wire lo_d = !sel && (class_d == CL_HOST || class_d == CL_SHORT || class_d == CL_DIV_A);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_switch_on_out <= 1'b0;
      constant_current_out <= 1'b0;
      discharge_out <= 1'b1;
      data_switch_on_out <= 1'b0;
      scheme_out <= SCH_NONE;
      high_current_limit_out <= 1'b0;
      low_current_limit_out <= 1'b0;
      pw_limit_out <= 1'b0;
      fault_oe_out <= 1'b0;
      status_oe_out <= 1'b0;
    end else begin
      power_switch_on_out <= switch_d;
      // early short goes straight to constant current
      constant_current_out <= pin_q.current_limit || pin_q.output_short;
      discharge_out <= (state_q != ST_RUN);
      data_switch_on_out <= data_d;
      scheme_out <= in_run ? scheme_q : SCH_NONE;
      high_current_limit_out <= !lo_d && !pw_limit_q;
      low_current_limit_out <= lo_d;
      pw_limit_out <= pw_limit_q;
      fault_oe_out <= fault_d;
      status_oe_out <= status_d;
    end
  end
  assign fault_n_out = 1'b0;
  assign status_n_out = 1'b0;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_thermal_switch_off: assert property (thermal_off_q |=> !power_switch_on_out)
    else $error("switch on during thermal shutdown");
  a_hot_trip_sets: assert property (pin_q.temp_over_155 |=> thermal_off_q)
    else $error("155C trip missed");
  a_warm_limit_trip: assert property (pin_q.temp_over_135 && pin_q.current_limit |=> ##1 !power_switch_on_out)
    else $error("135C with limit left switch on");
  a_fault_temp_now: assert property (therm_trip |=> fault_oe_out)
    else $error("over-temperature fault not immediate");
  a_fault_deglitch: assert property ($rose(pin_q.current_limit) && !thermal_off_q && !therm_trip
    |=> !fault_oe_out)
    else $error("current limit reported without deglitch");
  a_lockout_off: assert property (!supply_ok_q |=> ##1 !power_switch_on_out)
    else $error("switch on under lockout");
  a_data_in_disch: assert property (state_q == ST_DISCH |=> !data_switch_on_out && !power_switch_on_out)
    else $error("data or power switch on in discharge");
  a_data_dedicated: assert property (in_run && class_d == CL_AUTO |=> !data_switch_on_out)
    else $error("data switch closed in dedicated mode");
  a_short_entry: assert property (go_short && run_ok |=> state_q == ST_DISCH && pend_q == SCH_SHORT)
    else $error("shorted device did not start discharge");
  a_release_back: assert property (line_free && run_ok |=> scheme_q == SCH_DIV_A)
    else $error("release did not return to scheme a");
  a_host_no_disch: assert property (in_run && class_q == CL_HOST && class_d == CL_HOST && run_ok
    |=> state_q == ST_RUN)
    else $error("host variant change discharged");
  a_disch_length: assert property ($rose(state_q == ST_DISCH) && !pw_disch_q && run_ok
    |-> disch_cnt_q == PORT_DISCH_CNT)
    else $error("discharge length wrong");
  c_short_path: cover property (go_short ##[1:1000] scheme_q == SCH_SHORT);
  c_div_b: cover property (go_div_b);
  c_pw_wake: cover property (pw_hit);
  c_load_on: cover property ($rose(load_q));
endmodule
`default_nettype wire

// [dv/port_device_model.sv]
`default_nettype none
// ****************************************
// attached portable device seen through its sense lines
// ****************************************
module port_device_model import charge_port_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] attach_in,
  input wire logic keep_high_in,
  input wire logic power_on_in,
  input wire line_scheme_t scheme_in,
  output logic shorted_seen_out,
  output logic release_out,
  output logic over_750_out,
  output logic high_on_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run_a;
  assign run_a = power_on_in && (scheme_in == SCH_DIV_A);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shorted_seen_out <= 1'h0;
      release_out <= 1'h0;
      over_750_out <= 1'h0;
      high_on_out <= 1'h0;
    end else begin
      // a shorted-line device stops probing once it is answered
      shorted_seen_out <= run_a && (attach_in == 2'h1);
      release_out <= (attach_in == 2'h0) && (scheme_in == SCH_SHORT);
      over_750_out <= run_a && (attach_in == 2'h3);
      high_on_out <= power_on_in && (scheme_in == SCH_DIV_B) && keep_high_in;
    end
  end
endmodule
`default_nettype wire

// [dv/usb_charge_port_mode_control_tb.sv]
`default_nettype none
module usb_charge_port_mode_control_tb import charge_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals and expected mode table
  // ****************************************
  typedef struct packed {logic ds; logic [1:0] sch; logic hi; logic st; logic pwr;} row_t;
  // one row per {mode bits 1..3, limit select}
  // short timer counts so that every timed path finishes within the run
  localparam logic [31:0] T_LOAD_ON = 32'h14;
  localparam logic [31:0] T_LOAD_OFF = 32'h1E;
  localparam logic [31:0] T_PW_IDLE = 32'h28;
  localparam logic [31:0] T_PW_DISCH = 32'hA;
  localparam logic [31:0] T_PORT_DISCH = 32'h8;
  localparam logic [31:0] T_DEGLITCH = 32'h6;
  localparam logic [31:0] T_DIV_B_TEST = 32'hC;
  // off modes still select the high limit
  localparam row_t ROWS [16] = '{6'h04, 6'h04, 6'h0D, 6'h0F, 6'h21, 6'h25, 6'h0D, 6'h0D,
    6'h19, 6'h1D, 6'h09, 6'h0D, 6'h21, 6'h25, 6'h21, 6'h25};
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  pin_sense_t p;
  pin_sense_t pins;
  logic [1:0] attach;
  logic keep;
  logic pwr, cc, dis, ds, hi, lo, pwl, f_n, f_oe, s_n, s_oe;
  logic m_short, m_rel, m_750, m_hon;
  line_scheme_t sch;
  int miscompares = 0;
  int tests_run = 0;
  int n_dis, ds_dis, pw_dis;
  always #2 clk_in = ~clk_in;
  always_comb begin
    pins = p;
    pins.shorted_dev_seen = m_short;
    pins.data_line_release = m_rel;
    pins.charge_over_750 = m_750;
    pins.high_current_on = m_hon;
  end
  charge_port_ctrl #(.LOAD_ON_CNT(T_LOAD_ON), .LOAD_OFF_CNT(T_LOAD_OFF), .PW_IDLE_CNT(T_PW_IDLE),
    .PW_DISCH_CNT(T_PW_DISCH), .PORT_DISCH_CNT(T_PORT_DISCH), .CL_DEGLITCH_CNT(T_DEGLITCH),
    .DIV_B_TEST_CNT(T_DIV_B_TEST)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .pins_in(pins), .power_switch_on_out(pwr),
    .constant_current_out(cc), .discharge_out(dis), .data_switch_on_out(ds), .scheme_out(sch),
    .high_current_limit_out(hi), .low_current_limit_out(lo), .pw_limit_out(pwl), .fault_n_out(f_n),
    .fault_oe_out(f_oe), .status_n_out(s_n), .status_oe_out(s_oe));
  port_device_model model (.clk_in(clk_in), .rst_n_in(rst_n_in), .attach_in(attach), .keep_high_in(keep),
    .power_on_in(pwr), .scheme_in(sch), .shorted_seen_out(m_short), .release_out(m_rel),
    .over_750_out(m_750), .high_on_out(m_hon));
  // ****************************************
  // helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
      n_dis += int'(dis === 1'h1);
      ds_dis += int'(dis === 1'h1 && ds !== 1'h0);
      pw_dis += int'(dis === 1'h1 && pwr !== 1'h0);
    end
  endtask
  task automatic clr();
    n_dis = 0;
    ds_dis = 0;
    pw_dis = 0;
  endtask
  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic set_mode(input logic [3:0] m);
    {p.mode_select_bit1, p.mode_select_bit2, p.mode_select_bit3, p.limit_select} = m;
  endtask
  task automatic go(input logic [3:0] m);
    set_mode(4'h0);
    step(8);
    set_mode(m);
    step(12);
  endtask
  task automatic wait_sch(input line_scheme_t e, input int max);
    for (int i = 0; i < max && sch !== e; i++) step(1);
    chk(sch === e, "scheme not reached");
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    end_sim();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    p = '0;
    attach = 2'h0;
    keep = 1'h0;
    clr();
    p.enable = 1'h1;
    p.supply_above_on = 1'h1;
    repeat (20) @(posedge clk_in);
    #1;
    chk(dis === 1'h1 && pwr === 1'h0 && ds === 1'h0, "reset outputs");
    rst_n_in = 1'h1;
    $display("test done: reset");
    for (int i = 0; i < 16; i++) begin
      go(4'(i));
      chk(ds === ROWS[i].ds, "table data switch");
      chk(sch === ROWS[i].sch, "table scheme");
      chk(hi === ROWS[i].hi, "table limit");
      chk(lo === (i inside {4, 8, 10, 12, 14}), "table low limit");
      chk(s_oe === ROWS[i].st, "table status");
      chk(pwr === ROWS[i].pwr && dis === !ROWS[i].pwr, "table power");
    end
    $display("test done: mode table");
    p.load_above_hi = 1'h1;
    step(12);
    chk(s_oe === 1'h0, "status too early");
    step(16);
    chk(s_oe === 1'h1 && s_n === 1'h0, "status not set");
    p.load_above_hi = 1'h0;
    p.load_below_lo = 1'h1;
    step(20);
    chk(s_oe === 1'h1, "status released early");
    step(20);
    chk(s_oe === 1'h0, "status not released");
    p.primary_detect = 1'h1;
    step(5);
    chk(s_oe === 1'h1, "primary detection");
    p.primary_detect = 1'h0;
    p.load_below_lo = 1'h0;
    clr();
    set_mode(4'hE);
    step(12);
    set_mode(4'hF);
    step(12);
    chk(n_dis == 0 && pwr === 1'h1 && ds === 1'h1, "host variant swap");
    $display("test done: load status");
    p.current_limit = 1'h1;
    step(4);
    chk(f_oe === 1'h0, "limit not deglitched");
    step(10);
    chk(f_oe === 1'h1 && f_n === 1'h0 && cc === 1'h1, "limit fault");
    chk(ds === 1'h1, "data switch in limit");
    p.current_limit = 1'h0;
    step(6);
    chk(f_oe === 1'h0, "fault not cleared");
    p.temp_over_155 = 1'h1;
    step(4);
    chk(f_oe === 1'h1, "thermal fault");
    step(1);
    chk(pwr === 1'h0, "high trip");
    p.temp_over_155 = 1'h0;
    p.temp_cooled = 1'h1;
    step(8);
    chk(pwr === 1'h1 && f_oe === 1'h0, "restart");
    p.temp_cooled = 1'h0;
    p.temp_over_135 = 1'h1;
    step(6);
    chk(pwr === 1'h1, "low trip alone");
    p.current_limit = 1'h1;
    step(6);
    chk(pwr === 1'h0, "low trip in limit");
    p.temp_over_135 = 1'h0;
    p.current_limit = 1'h0;
    p.temp_cooled = 1'h1;
    step(8);
    chk(pwr === 1'h1, "cycle back on");
    p.temp_cooled = 1'h0;
    p.supply_above_on = 1'h0;
    p.supply_below_off = 1'h1;
    p.output_short = 1'h1;
    step(8);
    chk(pwr === 1'h0 && cc === 1'h1, "lockout and early short");
    p.supply_below_off = 1'h0;
    p.output_short = 1'h0;
    step(8);
    chk(pwr === 1'h0 && cc === 1'h0, "hysteresis");
    p.supply_above_on = 1'h1;
    step(12);
    chk(pwr === 1'h1, "lockout release");
    p.enable = 1'h0;
    step(8);
    chk(ds === 1'h0 && pwr === 1'h0, "disabled");
    p.enable = 1'h1;
    step(12);
    chk(ds === 1'h1, "enabled");
    $display("test done: protection");
    go(4'h2);
    clr();
    attach = 2'h1;
    wait_sch(SCH_SHORT, 40);
    chk(n_dis > 0 && ds_dis == 0 && pw_dis == 0, "shorted entry");
    step(2);
    chk(pwr === 1'h1 && dis === 1'h0, "switch back on");
    clr();
    attach = 2'h0;
    wait_sch(SCH_DIV_A, 20);
    step(20);
    chk(sch === SCH_DIV_A && n_dis == 0, "divider a kept");
    keep = 1'h1;
    attach = 2'h3;
    wait_sch(SCH_DIV_B, 60);
    chk(n_dis > 0 && pw_dis == 0 && ds_dis == 0, "to divider b");
    step(40);
    chk(sch === SCH_DIV_B, "divider b kept");
    keep = 1'h0;
    go(4'h2);
    wait_sch(SCH_DIV_B, 60);
    clr();
    wait_sch(SCH_DIV_A, 80);
    chk(n_dis > 0, "revert discharge");
    go(4'hA);
    clr();
    step(30);
    chk(sch === SCH_DIV_A && n_dis == 0, "forced divider a");
    attach = 2'h0;
    go(4'h8);
    clr();
    step(20);
    chk(sch === SCH_SHORT && n_dis == 0, "forced shorted");
    $display("test done: automatic charging");
    go(4'h3);
    p.pw_idle_low = 1'h1;
    step(30);
    chk(pwl === 1'h0, "idle limit early");
    step(20);
    chk(pwl === 1'h1 && s_oe === 1'h0 && hi === 1'h0, "idle limit");
    p.pw_idle_low = 1'h0;
    clr();
    p.pw_limit_hit = 1'h1;
    step(5);
    chk(s_oe === 1'h1, "wake status");
    p.pw_limit_hit = 1'h0;
    step(30);
    chk(n_dis >= 10 && pwl === 1'h0 && hi === 1'h1 && pwr === 1'h1, "wake restore");
    $display("test done: power wake");
    end_sim();
  end
endmodule
`default_nettype wire
